//--- spr_pkg.sv
// Overview of operation
// - Base plus 0x4 clears, 0x8 sets, 0xC inverts the written one bits.
// - Unimplemented bits, upper halfword included, read zero and ignore writes.
// - Direction has bits 6..0, all seven reset to one.
// - Pin readback and output latch hold bits 6..0; reset content not relied on.
// - Open-drain, pull-down, change enable and change status reset to zero.
// - Pull-up enable has bits 6..0, all seven reset to zero.
`default_nettype none
package spr_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int SPR_PINS = 7;
  localparam int SPR_ADDR_W = 16;
  localparam int SPR_DATA_W = 32;
  // ****************************************
  // Register base byte addresses
  // ****************************************
  localparam logic [15:0] OFS_DIR = 16'h6510;
  localparam logic [15:0] OFS_PORT = 16'h6520;
  localparam logic [15:0] OFS_LAT = 16'h6530;
  localparam logic [15:0] OFS_ODC = 16'h6540;
  localparam logic [15:0] OFS_PU = 16'h6550;
  localparam logic [15:0] OFS_PD = 16'h6560;
  localparam logic [15:0] OFS_CTRL = 16'h6570;
  localparam logic [15:0] OFS_EN = 16'h6580;
  localparam logic [15:0] OFS_STAT = 16'h6590;
  localparam logic [15:0] OFS_IRQ_STAT = 16'h65A0;
  localparam logic [15:0] OFS_IRQ_MASK = 16'h65B0;
  // ****************************************
  // Alias operations in address bits 3:2
  // ****************************************
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_CLR = 2'h1;
  localparam logic [1:0] OP_SET = 2'h2;
  localparam logic [1:0] OP_INV = 2'h3;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_IDLE_BIT = 13;
  localparam int IRQ_CHANGE_BIT = 0;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [6:0] RST_DIR = 7'h7F;
  localparam logic [6:0] RST_PIN = 7'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
endpackage
`default_nettype wire

//--- spr_port_regs.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module spr_port_regs
  import spr_pkg::*;
#(
  parameter int P_PINS = SPR_PINS
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [SPR_ADDR_W-1:0] i_addr,
  input wire logic [SPR_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_idle,
  input wire logic [P_PINS-1:0] i_pin_in,
  output logic [SPR_DATA_W-1:0] o_rdata,
  output logic [P_PINS-1:0] o_pin_out,
  output logic [P_PINS-1:0] o_pin_oe,
  output logic [P_PINS-1:0] o_pull_up,
  output logic [P_PINS-1:0] o_pull_down,
  output logic o_change_event,
  output logic o_irq
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
    hit = (addr[15:4] == ofs[15:4]);
  endfunction

  function automatic logic [15:0] apply(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] op);
    case (op)
      OP_CLR: apply = old & ~wd;
      OP_SET: apply = old | wd;
      OP_INV: apply = old ^ wd;
      default: apply = wd;
    endcase
  endfunction

  function automatic logic [P_PINS-1:0] upd(input logic [P_PINS-1:0] old, input logic [15:0] wd,
                                          input logic [1:0] op);
    logic [15:0] res;
    res = apply({{(16-P_PINS){1'b0}}, old}, wd, op);
    upd = res[P_PINS-1:0];
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [P_PINS-1:0] dir_reg, dir_next;
  logic [P_PINS-1:0] lat_reg, lat_next;
  logic [P_PINS-1:0] odc_reg, odc_next;
  logic [P_PINS-1:0] pu_reg, pu_next;
  logic [P_PINS-1:0] pd_reg, pd_next;
  logic [P_PINS-1:0] en_reg, en_next;
  logic [P_PINS-1:0] st_reg, st_next;
  logic [P_PINS-1:0] pin_reg, pin_next;
  logic [P_PINS-1:0] prev_reg, prev_next;
  logic on_reg, on_next;
  logic halt_idle_reg, halt_idle_next;
  logic irq_st_reg, irq_st_next;
  logic irq_mask_reg, irq_mask_next;
  logic [SPR_DATA_W-1:0] rdata_next;
  logic [P_PINS-1:0] out_next, oe_next;
  logic irq_next;
  logic [P_PINS-1:0] ev;
  logic active;
  logic [1:0] op;
  logic [15:0] addr;
  logic [15:0] wd;
  logic [15:0] ctrl_old, ctrl_new;
  logic [15:0] mask_new;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    addr = i_addr;
    wd = i_wdata[15:0];
    op = i_addr[3:2];
    dir_next = dir_reg;
    lat_next = lat_reg;
    odc_next = odc_reg;
    pu_next = pu_reg;
    pd_next = pd_reg;
    en_next = en_reg;
    st_next = st_reg;
    on_next = on_reg;
    halt_idle_next = halt_idle_reg;
    irq_mask_next = irq_mask_reg;
    ctrl_old = RST_HALF;
    ctrl_old[CTRL_ON_BIT] = on_reg;
    ctrl_old[CTRL_IDLE_BIT] = halt_idle_reg;
    ctrl_new = apply(ctrl_old, wd, op);
    mask_new = apply({15'h0000, irq_mask_reg}, wd, op);
    pin_next = i_pin_in;
    prev_next = pin_reg;
    // Bus writes, only bits 6..0 of pin registers kept
    if (i_wr) begin
      if (hit(addr, OFS_DIR)) begin
        dir_next = upd(dir_reg, wd, op);
      end
      if (hit(addr, OFS_PORT) || hit(addr, OFS_LAT)) begin
        lat_next = upd(lat_reg, wd, op);
      end
      if (hit(addr, OFS_ODC)) begin
        odc_next = upd(odc_reg, wd, op);
      end
      if (hit(addr, OFS_PU)) begin
        pu_next = upd(pu_reg, wd, op);
      end
      if (hit(addr, OFS_PD)) begin
        pd_next = upd(pd_reg, wd, op);
      end
      if (hit(addr, OFS_EN)) begin
        en_next = upd(en_reg, wd, op);
      end
      if (hit(addr, OFS_STAT)) begin
        st_next = upd(st_reg, wd, op);
      end
      if (hit(addr, OFS_CTRL)) begin
        on_next = ctrl_new[CTRL_ON_BIT];
        halt_idle_next = ctrl_new[CTRL_IDLE_BIT];
      end
      if (hit(addr, OFS_IRQ_MASK)) begin
        irq_mask_next = mask_new[IRQ_CHANGE_BIT];
      end
    end
    // Change detection, set wins over software clear
    active = on_reg && !(halt_idle_reg && i_idle);
    ev = active ? ((pin_reg ^ prev_reg) & en_reg) : {P_PINS{1'b0}};
    st_next = st_next | ev;
    // Sticky event flag cleared by reading it
    irq_st_next = irq_st_reg;
    if (i_rd && hit(addr, OFS_IRQ_STAT) && op == OP_WRITE) begin
      irq_st_next = 1'b0;
    end
    irq_st_next = irq_st_next | (|ev);
    irq_next = irq_st_next & irq_mask_next;
    // Read data, zero for aliases and unmapped addresses
    rdata_next = 32'h0000_0000;
    if (i_rd && op == OP_WRITE) begin
      case (addr[15:4])
        OFS_DIR[15:4]: rdata_next[P_PINS-1:0] = dir_reg;
        OFS_PORT[15:4]: rdata_next[P_PINS-1:0] = pin_reg;
        OFS_LAT[15:4]: rdata_next[P_PINS-1:0] = lat_reg;
        OFS_ODC[15:4]: rdata_next[P_PINS-1:0] = odc_reg;
        OFS_PU[15:4]: rdata_next[P_PINS-1:0] = pu_reg;
        OFS_PD[15:4]: rdata_next[P_PINS-1:0] = pd_reg;
        OFS_CTRL[15:4]: rdata_next[15:0] = ctrl_old;
        OFS_EN[15:4]: rdata_next[P_PINS-1:0] = en_reg;
        OFS_STAT[15:4]: rdata_next[P_PINS-1:0] = st_reg;
        OFS_IRQ_STAT[15:4]: rdata_next[IRQ_CHANGE_BIT] = irq_st_reg;
        OFS_IRQ_MASK[15:4]: rdata_next[IRQ_CHANGE_BIT] = irq_mask_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    // Pin drive, open drain only pulls low
    out_next = lat_next & ~odc_next;
    oe_next = ~dir_next & (~odc_next | ~lat_next);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      dir_reg <= RST_DIR;
      lat_reg <= RST_PIN;
      odc_reg <= RST_PIN;
      pu_reg <= RST_PIN;
      pd_reg <= RST_PIN;
      en_reg <= RST_PIN;
      st_reg <= RST_PIN;
      pin_reg <= RST_PIN;
      prev_reg <= RST_PIN;
      on_reg <= 1'b0;
      halt_idle_reg <= 1'b0;
      irq_st_reg <= 1'b0;
      irq_mask_reg <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_pin_out <= RST_PIN;
      o_pin_oe <= RST_PIN;
      o_pull_up <= RST_PIN;
      o_pull_down <= RST_PIN;
      o_change_event <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      dir_reg <= dir_next;
      lat_reg <= lat_next;
      odc_reg <= odc_next;
      pu_reg <= pu_next;
      pd_reg <= pd_next;
      en_reg <= en_next;
      st_reg <= st_next;
      pin_reg <= pin_next;
      prev_reg <= prev_next;
      on_reg <= on_next;
      halt_idle_reg <= halt_idle_next;
      irq_st_reg <= irq_st_next;
      irq_mask_reg <= irq_mask_next;
      o_rdata <= rdata_next;
      o_pin_out <= out_next;
      o_pin_oe <= oe_next;
      o_pull_up <= pu_next;
      o_pull_down <= pd_next;
      o_change_event <= |ev;
      o_irq <= irq_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  a_dir_reset_ones: assert property (disable iff (1'b0) !i_rst_n |=> dir_reg == RST_DIR)
    else $error("direction not all ones after reset");
  a_zero_reset_regs: assert property (disable iff (1'b0) !i_rst_n |=>
      (odc_reg | pd_reg | en_reg | st_reg) == RST_PIN)
    else $error("zero-reset register not zero");
  a_pull_up_reset: assert property (disable iff (1'b0) !i_rst_n |=> pu_reg == RST_PIN)
    else $error("pull-up enable not cleared by reset");
  a_clr_alias_dir: assert property (i_wr && hit(i_addr, OFS_DIR) && i_addr[3:2] == OP_CLR |=>
      dir_reg == ($past(dir_reg) & ~$past(i_wdata[6:0])))
    else $error("clear alias wrong");
  a_set_alias_en: assert property (i_wr && hit(i_addr, OFS_EN) && i_addr[3:2] == OP_SET |=>
      en_reg == ($past(en_reg) | $past(i_wdata[6:0])))
    else $error("set alias wrong");
  a_inv_alias_odc: assert property (i_wr && hit(i_addr, OFS_ODC) && i_addr[3:2] == OP_INV |=>
      odc_reg == ($past(odc_reg) ^ $past(i_wdata[6:0])))
    else $error("invert alias wrong");
  a_upper_read_zero: assert property (i_rd && !hit(i_addr, OFS_CTRL) |=> o_rdata[31:7] == 25'h0)
    else $error("unimplemented bits read nonzero");
  a_port_readback: assert property (i_rd && hit(i_addr, OFS_PORT) && i_addr[3:2] == OP_WRITE |=>
      o_rdata[6:0] == $past(pin_reg))
    else $error("pin readback mismatch");
  a_change_sets: assert property (|ev |=> ((st_reg & $past(ev)) == $past(ev)) && o_change_event)
    else $error("change did not set status");
  a_no_change_off: assert property (!on_reg |=> !o_change_event)
    else $error("event while change notice off");
  a_irq_level: assert property (##1 o_irq == (irq_st_reg & irq_mask_reg))
    else $error("interrupt level mismatch");

  a_set_alias_dir: assert property (i_wr && hit(i_addr, OFS_DIR) && i_addr[3:2] == OP_SET |=>
      dir_reg == ($past(dir_reg) | $past(i_wdata[6:0])))
    else $error("direction set alias wrong");
  a_inv_alias_dir: assert property (i_wr && hit(i_addr, OFS_DIR) && i_addr[3:2] == OP_INV |=>
      dir_reg == ($past(dir_reg) ^ $past(i_wdata[6:0])))
    else $error("direction invert alias wrong");
  a_clr_alias_lat: assert property (i_wr && hit(i_addr, OFS_LAT) && i_addr[3:2] == OP_CLR |=>
      lat_reg == ($past(lat_reg) & ~$past(i_wdata[6:0])))
    else $error("latch clear alias wrong");
  a_set_alias_lat: assert property (i_wr && hit(i_addr, OFS_LAT) && i_addr[3:2] == OP_SET |=>
      lat_reg == ($past(lat_reg) | $past(i_wdata[6:0])))
    else $error("latch set alias wrong");
  a_base_write_lat: assert property (i_wr && hit(i_addr, OFS_LAT) && i_addr[3:2] == OP_WRITE |=>
      lat_reg == $past(i_wdata[6:0]))
    else $error("latch write wrong");
  a_clr_alias_stat: assert property (i_wr && hit(i_addr, OFS_STAT) && i_addr[3:2] == OP_CLR |=>
      st_reg == (($past(st_reg) & ~$past(i_wdata[6:0])) | $past(ev)))
    else $error("status clear alias wrong");
  a_set_alias_ctrl: assert property (i_wr && hit(i_addr, OFS_CTRL) && i_addr[3:2] == OP_SET |=>
      halt_idle_reg == ($past(halt_idle_reg) | $past(i_wdata[CTRL_IDLE_BIT])))
    else $error("control set alias wrong");
  a_alias_read_zero: assert property (i_rd && i_addr[3:2] != OP_WRITE |=>
      o_rdata == 32'h0000_0000)
    else $error("alias read nonzero");
  a_ctrl_read_bits: assert property (i_rd && hit(i_addr, OFS_CTRL) |=>
      o_rdata[31:16] == 16'h0000 && o_rdata[14] == 1'b0 && o_rdata[12:0] == 13'h0000)
    else $error("control unused bits read nonzero");
  a_dir_readback: assert property (i_rd && hit(i_addr, OFS_DIR) && i_addr[3:2] == OP_WRITE |=>
      o_rdata[6:0] == $past(dir_reg))
    else $error("direction readback mismatch");
  a_stat_readback: assert property (i_rd && hit(i_addr, OFS_STAT) && i_addr[3:2] == OP_WRITE |=>
      o_rdata[6:0] == $past(st_reg))
    else $error("status readback mismatch");
  a_pin_sampled: assert property (i_rst_n |=>
      pin_reg == $past(i_pin_in))
    else $error("pin level not sampled");
  a_pin_drive: assert property (i_rst_n |=>
      o_pin_out == (lat_reg & ~odc_reg) && o_pin_oe == (~dir_reg & (~odc_reg | ~lat_reg)))
    else $error("pin drive mismatch");
  a_pull_outputs: assert property (i_rst_n |=>
      o_pull_up == pu_reg && o_pull_down == pd_reg)
    else $error("pull enables not driven");
  a_halt_in_idle: assert property (halt_idle_reg && i_idle |=>
      !o_change_event)
    else $error("event while halted in idle");
  a_irq_sets: assert property (|ev |=>
      irq_st_reg)
    else $error("event did not set interrupt status");
  a_irq_read_clear: assert property (i_rd && hit(i_addr, OFS_IRQ_STAT) && i_addr[3:2] == OP_WRITE && !(|ev) |=>
      !irq_st_reg)
    else $error("interrupt status not cleared by read");
  a_mask_write: assert property (i_wr && hit(i_addr, OFS_IRQ_MASK) && i_addr[3:2] == OP_WRITE |=>
      irq_mask_reg == $past(i_wdata[IRQ_CHANGE_BIT]))
    else $error("interrupt mask write wrong");
  a_rdata_idle_zero: assert property (!i_rd |=>
      o_rdata == 32'h0000_0000)
    else $error("read data not zero between reads");

  // ****************************************
  // Cover points
  // ****************************************
  c_clr_write: cover property (i_wr && i_addr[3:2] == OP_CLR);
  c_change_event: cover property (o_change_event ##1 o_irq);
  c_read_clear: cover property (o_irq ##1 i_rd && hit(i_addr, OFS_IRQ_STAT) ##1 !irq_st_reg);
  c_open_drain: cover property (odc_reg != RST_PIN && o_pin_oe != RST_PIN);
  c_halt_idle: cover property (on_reg && halt_idle_reg && i_idle);
endmodule
`default_nettype wire

//--- spr_port_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module spr_port_regs_bench
  import spr_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [SPR_ADDR_W-1:0] i_addr = 16'h0000;
  logic [SPR_DATA_W-1:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_idle = 1'b0;
  logic [SPR_PINS-1:0] i_pin_in = 7'h00;
  logic [SPR_DATA_W-1:0] o_rdata;
  logic [SPR_PINS-1:0] o_pin_out, o_pin_oe, o_pull_up, o_pull_down;
  logic o_change_event, o_irq;
  logic rd_q = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] w;
  logic [6:0] c, s, v, p, od, dr;
  int num_errors = 0;
  int checks = 0;
  int n;
  // ****************************************
  // Clock, design and read monitor
  // ****************************************
  always #2.5 i_clock = ~i_clock;
  spr_port_regs dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_idle(i_idle), .i_pin_in(i_pin_in), .o_rdata(o_rdata), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_pull_up(o_pull_up), .o_pull_down(o_pull_down), .o_change_event(o_change_event),
    .o_irq(o_irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge i_clock) begin
    if (rd_q) check(o_rdata, exp_q.pop_front());
    rd_q <= i_rd;
  end
  // ****************************************
  // Bus tasks and closing
  // ****************************************
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    exp_q.push_back(e);
    @(posedge i_clock);
  endtask
  task automatic idle(input int k);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (k) @(posedge i_clock);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #10000;
    num_errors++;
    conclude();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(32'hfd140033));
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(OFS_DIR, 32'h0000_007F);
    foreach (dr[i]) rd(OFS_ODC + 16'(i * 16), 32'h0000_0000);
    idle(2);
    @(negedge i_clock);
    check(32'(o_pin_oe), 32'h0000_0000);
    @(posedge i_clock);
    $display("test reset done");
    w = $urandom;
    c = 7'($urandom);
    s = 7'($urandom);
    v = 7'($urandom);
    od = 7'($urandom);
    wr(OFS_LAT, w);
    wr(OFS_LAT + 16'h0004, 32'(c));
    wr(OFS_LAT + 16'h0008, 32'(s));
    wr(OFS_LAT + 16'h000C, 32'(v));
    rd(OFS_LAT, 32'(((w[6:0] & ~c) | s) ^ v));
    wr(OFS_DIR + 16'h0004, 32'hFFFF_FFFF);
    rd(OFS_DIR, 32'h0000_0000);
    wr(OFS_DIR + 16'h0008, 32'h0000_0055);
    wr(OFS_DIR + 16'h000C, 32'hFFFF_FFFF);
    dr = 7'h2A;
    rd(OFS_DIR, 32'h0000_002A);
    wr(OFS_ODC, {25'h1FF_FFFF, od});
    wr(OFS_ODC + 16'h000C, 32'h0000_007F);
    od = ~od;
    wr(OFS_PU, 32'hFFFF_FF81);
    wr(OFS_PD, 32'hFFFF_FFFF);
    rd(OFS_PU, 32'h0000_0001);
    rd(OFS_PD, 32'h0000_007F);
    rd(OFS_DIR + 16'h0004, 32'h0000_0000);
    rd(16'h6600, 32'h0000_0000);
    idle(2);
    w[6:0] = ((w[6:0] & ~c) | s) ^ v;
    @(negedge i_clock);
    check(32'(o_pin_out), {25'h000_0000, w[6:0] & ~od});
    check(32'(o_pin_oe), {25'h000_0000, ~dr & (~od | ~w[6:0])});
    check(32'({o_pull_up, o_pull_down}), 32'h0000_00FF);
    @(posedge i_clock);
    $display("test alias done");
    p = 7'($urandom);
    i_pin_in <= p;
    idle(3);
    rd(OFS_PORT, 32'(p));
    wr(OFS_EN + 16'h0008, 32'h0000_007F);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_8000);
    idle(2);
    i_pin_in <= ~p;
    n = 0;
    while (o_change_event !== 1'b1 && n < 6) begin
      @(negedge i_clock);
      n++;
    end
    check(32'({o_change_event, o_irq}), 32'h0000_0003);
    @(negedge i_clock);
    check(32'(o_change_event), 32'h0000_0000);
    @(posedge i_clock);
    rd(OFS_STAT, 32'h0000_007F);
    rd(OFS_IRQ_STAT, 32'h0000_0001);
    rd(OFS_IRQ_STAT, 32'h0000_0000);
    wr(OFS_STAT + 16'h0004, 32'h0000_007F);
    rd(OFS_STAT, 32'h0000_0000);
    idle(2);
    @(negedge i_clock);
    check(32'(o_irq), 32'h0000_0000);
    @(posedge i_clock);
    wr(OFS_CTRL + 16'h0008, 32'h0000_2000);
    i_idle <= 1'b1;
    idle(2);
    i_pin_in <= p;
    idle(6);
    @(negedge i_clock);
    check(32'({o_change_event, o_irq}), 32'h0000_0000);
    @(posedge i_clock);
    rd(OFS_STAT, 32'h0000_0000);
    idle(3);
    $display("test change done");
    conclude();
  end
endmodule
`default_nettype wire
